// ==== pkg/dlp_pkg.sv ====
// dlp_pkg: shared constants and types for the low-power reset sequencer
// assumes a single 10 MHz clock and active-low asynchronous reset
`default_nettype none
package dlp_pkg;
  // domain power modes
  typedef enum logic [1:0] {
    DLP_DOM_ACTIVE   = 2'h0,
    DLP_DOM_BUSHALT  = 2'h1,
    DLP_DOM_PWRDOWN  = 2'h2
  } dlp_dom_t;
  // system modes
  typedef enum logic [1:0] {
    DLP_SYS_RUN     = 2'h0,
    DLP_SYS_STOP    = 2'h1,
    DLP_SYS_STANDBY = 2'h2
  } dlp_sys_t;
  // cpu modes
  typedef enum logic [1:0] {
    DLP_CPU_RUN      = 2'h0,
    DLP_CPU_CLKHALT  = 2'h1,
    DLP_CPU_SUBHALT  = 2'h2
  } dlp_cpu_t;
  localparam int unsigned DLP_NUM_SRC     = 8;
  localparam logic [7:0]  DLP_SRC_POR     = 8'h01;
  localparam int unsigned DLP_SRC_STBY_BIT = 7;
  // reset stretch length in cycles
  localparam int unsigned DLP_RST_CYCLES  = 4;
  // clock select and gpio mode codes; 0 is the internal high-speed oscillator
  localparam logic [1:0]  DLP_CLK_HSOSC   = 2'h0;
  localparam logic [1:0]  DLP_GPIO_ANALOG = 2'h3;
endpackage
`default_nettype wire

// ==== src/dlp_domain.sv ====
// dlp_domain: mode tracker for one power domain
// assumes all inputs synchronous to clk_in
`default_nettype none
module dlp_domain
  import dlp_pkg::*;
(
  // clock and reset
  input  wire logic     clk_in,
  input  wire logic     rst_n_in,
  input  wire logic     sys_rst_in,
  // low-power status of parts
  input  wire logic     all_idle_in,
  input  wire logic     pd_req_in,
  input  wire logic     wake_in,
  // resulting mode
  output dlp_pkg::dlp_dom_t mode_out
);
  // mode only deepens when every part idles; wake returns to active
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_out <= DLP_DOM_ACTIVE;
    end else if (sys_rst_in || wake_in) begin
      mode_out <= DLP_DOM_ACTIVE;
    end else if (all_idle_in) begin
      mode_out <= pd_req_in ? DLP_DOM_PWRDOWN : DLP_DOM_BUSHALT;
    end
  end
  // any active part leaves the mode as is: no branch taken
endmodule
`default_nettype wire

// ==== src/dlp_sequencer.sv ====
// dlp_sequencer: cpu, domain and system low-power sequencing with resets
// assumes synchronous inputs; sits in the control domain, which is powered off in standby
//
// Notes on behaviour
// - six low-power states are provided
// - wait instructions, or handler return with the sleep-after-handler flag set, enter halt
// - domain deepens only when all parts idle
// - active part holds domain in current mode
// - stop/standby need no wakeup and halted domains
// - only allowed system/domain mode combinations
// - power-on clears all; system reset keeps some
// - eight sources raise system reset
// - after reset clock select is high-speed oscillator
// - after reset pins come up analog
// - sequencer lives in the control domain; ctrl_domain_on_out turns that domain off in standby
`default_nettype none
module dlp_sequencer
  import dlp_pkg::*;
(
  // clock and power-on reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // core signalling
  input  wire logic       wait_interrupt_instruction_in,
  input  wire logic       wait_event_instruction_in,
  input  wire logic       handler_return_in,
  input  wire logic       sleep_after_handler_flag_in,
  input  wire logic       deep_sleep_in,
  input  wire logic       cpu_wake_in,
  // domain peripheral idle status and power-down requests
  input  wire logic       core_periph_idle_in,
  input  wire logic       periph_domain_idle_in,
  input  wire logic       core_pd_req_in,
  input  wire logic       periph_pd_req_in,
  input  wire logic       sys_standby_req_in,
  // wakeup_event_controller
  input  wire logic       wakeup_pending_in,
  input  wire logic       wake_core_in,
  // reset sources
  input  wire logic       brownout_in,
  input  wire logic       external_reset_pin_n_in,
  input  wire logic       window_wdog_in,
  input  wire logic       indep_wdog_in,
  input  wire logic       sw_reset_in,
  input  wire logic       lp_security_in,
  // mode outputs
  output dlp_pkg::dlp_cpu_t cpu_mode_out,
  output dlp_pkg::dlp_dom_t core_domain_mode_out,
  output dlp_pkg::dlp_dom_t periph_domain_mode_out,
  output dlp_pkg::dlp_dom_t ctrl_domain_mode_out,
  output dlp_pkg::dlp_sys_t sys_mode_out,
  output logic            sys_clk_en_out,
  // reset and after-reset defaults
  output logic            sys_rst_out,
  output logic [7:0]      rst_cause_out,
  output logic [1:0]      clk_sel_out,
  output logic [1:0]      gpio_mode_out,
  output logic            ctrl_domain_on_out
);
  // ******************************************************
  // reset source collection
  // ******************************************************
  logic [7:0] next_src;
  logic       por_pulse;
  logic       standby_exit;
  logic [2:0] rst_cnt;
  dlp_dom_t   core_mode;
  dlp_dom_t   periph_mode;
  // por is seen as the first cycle after release
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      por_pulse <= 1'b1;
    end else begin
      por_pulse <= 1'b0;
    end
  end
  // eight sources collected into one vector
  always_comb begin
    next_src = {standby_exit, lp_security_in, sw_reset_in, indep_wdog_in,
                window_wdog_in, ~external_reset_pin_n_in, brownout_in,
                por_pulse};
  end
  // stretch reset for a fixed count so all logic sees it
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_cnt     <= 3'(DLP_RST_CYCLES);
      sys_rst_out <= 1'b1;
    end else if (|next_src) begin
      rst_cnt     <= 3'(DLP_RST_CYCLES);
      sys_rst_out <= 1'b1;
    end else if (rst_cnt != 3'h0) begin
      rst_cnt     <= rst_cnt - 3'h1;
      sys_rst_out <= 1'b1;
    end else begin
      sys_rst_out <= 1'b0;
    end
  end
  // cause record is status: kept across system reset, cleared by por
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_cause_out <= DLP_SRC_POR;
    end else if (|next_src) begin
      rst_cause_out <= next_src;
    end
  end

  // ******************************************************
  // after-reset defaults
  // ******************************************************
  // software would change these later; block only restores them
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clk_sel_out   <= DLP_CLK_HSOSC;
      gpio_mode_out <= DLP_GPIO_ANALOG;
    end else if (sys_rst_out) begin
      clk_sel_out   <= DLP_CLK_HSOSC;
      gpio_mode_out <= DLP_GPIO_ANALOG;
    end
  end
  // control domain powered in every system mode except standby
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_domain_on_out <= 1'b1;
    end else begin
      ctrl_domain_on_out <= (sys_mode_out != DLP_SYS_STANDBY);
    end
  end

  // ******************************************************
  // cpu low-power state
  // ******************************************************
  logic cpu_sleep_trig;
  assign cpu_sleep_trig = wait_interrupt_instruction_in |
                          wait_event_instruction_in |
                          (handler_return_in & sleep_after_handler_flag_in);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cpu_mode_out <= DLP_CPU_RUN;
    end else if (sys_rst_out || cpu_wake_in || wake_core_in) begin
      cpu_mode_out <= DLP_CPU_RUN;
    end else if (cpu_mode_out == DLP_CPU_RUN && cpu_sleep_trig) begin
      cpu_mode_out <= deep_sleep_in ? DLP_CPU_SUBHALT
                                    : DLP_CPU_CLKHALT;
    end
  end

  // ******************************************************
  // domains
  // ******************************************************
  logic core_idle;
  logic periph_idle;
  logic wake_stop;
  assign core_idle   = (cpu_mode_out != DLP_CPU_RUN) & core_periph_idle_in;
  assign periph_idle = periph_domain_idle_in;
  assign wake_stop   = wakeup_pending_in & (sys_mode_out == DLP_SYS_STOP);

  dlp_domain u_core (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n_in),
    .sys_rst_in  (sys_rst_out),
    .all_idle_in (core_idle),
    .pd_req_in   (core_pd_req_in),
    .wake_in     (wake_stop & wake_core_in),
    .mode_out    (core_mode)
  );
  dlp_domain u_periph (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n_in),
    .sys_rst_in  (sys_rst_out),
    .all_idle_in (periph_idle),
    .pd_req_in   (periph_pd_req_in),
    .wake_in     (wake_stop & ~wake_core_in),
    .mode_out    (periph_mode)
  );

  // domain modes registered again so outputs come from flops
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      core_domain_mode_out   <= DLP_DOM_ACTIVE;
      periph_domain_mode_out <= DLP_DOM_ACTIVE;
    end else begin
      core_domain_mode_out   <= core_mode;
      periph_domain_mode_out <= periph_mode;
    end
  end

  // ******************************************************
  // system mode
  // ******************************************************
  logic doms_low;
  logic doms_off;
  assign doms_low = (core_mode != DLP_DOM_ACTIVE) &
                    (periph_mode != DLP_DOM_ACTIVE);
  assign doms_off = (core_mode == DLP_DOM_PWRDOWN) &
                    (periph_mode == DLP_DOM_PWRDOWN);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sys_mode_out <= DLP_SYS_RUN;
      standby_exit <= 1'b0;
    end else if (sys_rst_out) begin
      sys_mode_out <= DLP_SYS_RUN; // domains are reset as well
      standby_exit <= 1'b0;
    end else begin
      standby_exit <= 1'b0;
      unique case (sys_mode_out)
        DLP_SYS_RUN: begin
          if (!wakeup_pending_in && doms_low && !sys_rst_out) begin
            if (sys_standby_req_in && doms_off) begin
              sys_mode_out <= DLP_SYS_STANDBY;
            end else begin
              sys_mode_out <= DLP_SYS_STOP;
            end
          end
        end
        DLP_SYS_STOP: begin
          if (wakeup_pending_in) begin
            sys_mode_out <= DLP_SYS_RUN;
          end
        end
        DLP_SYS_STANDBY: begin
          // leaving standby goes through a system reset
          if (wakeup_pending_in) begin
            sys_mode_out <= DLP_SYS_RUN;
            standby_exit <= 1'b1;
          end
        end
        default: sys_mode_out <= DLP_SYS_RUN;
      endcase
    end
  end
  // control domain mode and system clock follow system mode
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_domain_mode_out <= DLP_DOM_ACTIVE;
      sys_clk_en_out       <= 1'b1;
    end else begin
      unique case (sys_mode_out)
        DLP_SYS_STOP:    ctrl_domain_mode_out <= DLP_DOM_BUSHALT;
        DLP_SYS_STANDBY: ctrl_domain_mode_out <= DLP_DOM_PWRDOWN;
        default:         ctrl_domain_mode_out <= DLP_DOM_ACTIVE;
      endcase
      sys_clk_en_out <= (sys_mode_out == DLP_SYS_RUN);
    end
  end

  // ******************************************************
  // checks
  // ******************************************************
  // all checks share the one clock and drop out during power-on reset
  default clocking chk_cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  sequence halt_trig_s;
    cpu_mode_out == DLP_CPU_RUN && cpu_sleep_trig && !sys_rst_out &&
    !cpu_wake_in && !wake_core_in;
  endsequence
  cpu_halt_entry_a: assert property (
    halt_trig_s |=> cpu_mode_out != DLP_CPU_RUN)
    else $error("cpu did not halt on wait");
  stop_needs_idle_a: assert property (
    $rose(sys_mode_out != DLP_SYS_RUN) |->
      !$past(wakeup_pending_in) && $past(doms_low))
    else $error("system left run without idle domains");
  standby_all_off_a: assert property (
    sys_mode_out == DLP_SYS_STANDBY |=>
      ctrl_domain_mode_out == DLP_DOM_PWRDOWN)
    else $error("standby without control powerdown");
  standby_doms_a: assert property (
    sys_mode_out == DLP_SYS_STANDBY |->
      core_mode == DLP_DOM_PWRDOWN && periph_mode == DLP_DOM_PWRDOWN)
    else $error("standby with a domain not powered down");
  stop_wake_a: assert property (
    sys_mode_out == DLP_SYS_STOP && wakeup_pending_in |=>
      sys_mode_out == DLP_SYS_RUN ##1 sys_clk_en_out)
    else $error("wakeup did not restore clock");
  busy_hold_a: assert property (
    !core_idle && !sys_rst_out && !(wake_stop && wake_core_in) |=>
      $stable(core_mode))
    else $error("busy domain changed mode");
  reset_src_a: assert property (
    (|next_src) |=> sys_rst_out [*4])
    else $error("reset source did not stretch reset");
  reset_default_a: assert property (
    sys_rst_out |=> clk_sel_out == DLP_CLK_HSOSC &&
      gpio_mode_out == DLP_GPIO_ANALOG)
    else $error("defaults not restored by reset");
  cause_kept_a: assert property (
    !(|next_src) |=> $stable(rst_cause_out))
    else $error("cause record lost");
  ctrl_on_a: assert property (
    sys_mode_out == DLP_SYS_RUN |=> ctrl_domain_on_out)
    else $error("control domain off while running");
endmodule
`default_nettype wire

// ==== tb/dlp_far_model.sv ====
// dlp_far_model: core and wakeup controller seen from the sequencer
// assumes the bench calls its tasks; outputs change at falling edges
`default_nettype none
module dlp_far_model (
  // clock
  input  wire logic clk_in,
  // core instruction pulses
  output logic      wfi_out,
  output logic      wfe_out,
  output logic      hret_out,
  // wakeup controller levels
  output logic      wake_core_out,
  output logic      pending_out
);
  timeunit 1ns;
  timeprecision 1ns;

  // quiet core and no pending source at time zero
  initial begin
    wfi_out       = 1'b0;
    wfe_out       = 1'b0;
    hret_out      = 1'b0;
    wake_core_out = 1'b0;
    pending_out   = 1'b0;
  end

  // one-cycle pulse: 0 wait-interrupt, 1 wait-event, 2 handler return
  task automatic core_pulse(input int kind);
    @(negedge clk_in);
    wfi_out  <= (kind == 0);
    wfe_out  <= (kind == 1);
    hret_out <= (kind == 2);
    @(negedge clk_in);
    wfi_out  <= 1'b0;
    wfe_out  <= 1'b0;
    hret_out <= 1'b0;
  endtask

  // pending is a level held until cleared, as a real pending flag
  task automatic set_pending(input logic p, input logic core);
    @(negedge clk_in);
    pending_out   <= p;
    wake_core_out <= core;
  endtask
endmodule
`default_nettype wire

// ==== tb/domain_low_power_reset_sequencer_tb.sv ====
// domain_low_power_reset_sequencer_tb: self-checking bench for the sequencer
// assumes dlp_pkg and dlp_far_model are compiled first
`default_nettype none
module domain_low_power_reset_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dlp_pkg::*;

  // ********************
  // signals
  // ********************
  logic       clk, rst_n, deep, cwake, flag, cidle, pidle, cpd, ppd, stby;
  logic [5:0] src;
  logic       wait_interrupt_instruction, wait_event_instruction, hret, wcore, pend;
  dlp_cpu_t   cpu_mode;
  dlp_dom_t   core_mode, per_mode, ctrl_mode;
  dlp_sys_t   sys_mode;
  logic       clk_en, sys_rst, ctrl_on;
  logic [7:0] cause;
  logic [1:0] clk_sel, gpio;
  int         error_cnt, samples_checked;

  // 100 ns clock and time-zero input values
  always #50 clk = ~clk;
  initial begin
    {clk, rst_n, deep, cwake, flag, cidle, pidle, cpd, ppd, stby} = '0;
    src = '0;
  end

  dlp_far_model far (.clk_in(clk), .wfi_out(wait_interrupt_instruction), .wfe_out(wait_event_instruction),
    .hret_out(hret), .wake_core_out(wcore), .pending_out(pend));

  dlp_sequencer uut (.clk_in(clk), .rst_n_in(rst_n),
    .wait_interrupt_instruction_in(wait_interrupt_instruction), .wait_event_instruction_in(wait_event_instruction),
    .handler_return_in(hret), .sleep_after_handler_flag_in(flag),
    .deep_sleep_in(deep), .cpu_wake_in(cwake),
    .core_periph_idle_in(cidle), .periph_domain_idle_in(pidle),
    .core_pd_req_in(cpd), .periph_pd_req_in(ppd),
    .sys_standby_req_in(stby), .wakeup_pending_in(pend),
    .wake_core_in(wcore), .brownout_in(src[0]),
    .external_reset_pin_n_in(~src[1]), .window_wdog_in(src[2]),
    .indep_wdog_in(src[3]), .sw_reset_in(src[4]),
    .lp_security_in(src[5]), .cpu_mode_out(cpu_mode),
    .core_domain_mode_out(core_mode), .periph_domain_mode_out(per_mode),
    .ctrl_domain_mode_out(ctrl_mode), .sys_mode_out(sys_mode),
    .sys_clk_en_out(clk_en), .sys_rst_out(sys_rst),
    .rst_cause_out(cause), .clk_sel_out(clk_sel),
    .gpio_mode_out(gpio), .ctrl_domain_on_out(ctrl_on));

  // ********************
  // helpers
  // ********************
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  // the stretch length is the designer's, so poll with a bound
  task automatic wait_rst_done();
    int k;
    k = 0;
    while (sys_rst !== 1'b0 && k < 30) begin
      cyc(1);
      k++;
    end
    check(sys_rst, 8'h00);
  endtask

  // ********************
  // scenarios
  // ********************
  task automatic t_reset();
    cyc(8);
    check(sys_rst, 8'h01);
    check(cause, DLP_SRC_POR);
    check(clk_sel, DLP_CLK_HSOSC);
    check(gpio, DLP_GPIO_ANALOG);
    cyc(8);
    rst_n = 1'b1;
    wait_rst_done();
    check(ctrl_on, 8'h01);
  endtask

  // wait instructions, handler return with and without the flag
  task automatic t_cpu();
    far.core_pulse(0);
    cyc(2);
    check(cpu_mode, DLP_CPU_CLKHALT);
    cwake = 1'b1;
    cyc(2);
    cwake = 1'b0;
    check(cpu_mode, DLP_CPU_RUN);
    far.core_pulse(2);
    cyc(2);
    check(cpu_mode, DLP_CPU_RUN);
    flag = 1'b1;
    far.core_pulse(2);
    cyc(2);
    check(cpu_mode, DLP_CPU_CLKHALT);
    cwake = 1'b1;
    cyc(2);
    cwake = 1'b0;
    deep  = 1'b1;
    far.core_pulse(1);
    cyc(2);
    check(cpu_mode, DLP_CPU_SUBHALT);
  endtask

  // domains deepen only when idle; stop held off by pending wakeup
  task automatic t_domain();
    ppd   = 1'b1;
    pidle = 1'b1;
    far.set_pending(1'b1, 1'b0);
    cyc(4);
    check(core_mode, DLP_DOM_ACTIVE);
    check(per_mode, DLP_DOM_PWRDOWN);
    cidle = 1'b1;
    cyc(4);
    check(core_mode, DLP_DOM_BUSHALT);
    check(sys_mode, DLP_SYS_RUN);
    far.set_pending(1'b0, 1'b0);
    cyc(4);
    check(sys_mode, DLP_SYS_STOP);
    check(ctrl_mode, DLP_DOM_BUSHALT);
    check(clk_en, 8'h00);
    cidle = 1'b0;
    far.set_pending(1'b1, 1'b1);
    cyc(4);
    check(sys_mode, DLP_SYS_RUN);
    check(clk_en, 8'h01);
    check(ctrl_mode, DLP_DOM_ACTIVE);
    check(core_mode, DLP_DOM_ACTIVE);
    check(per_mode, DLP_DOM_PWRDOWN);
    far.set_pending(1'b0, 1'b0);
  endtask

  // each of the six src inputs raises reset; causes are kept as status
  task automatic t_sources();
    logic [7:0] exp;
    exp = DLP_SRC_POR;
    for (int i = 0; i < 6; i++) begin
      exp = 8'h02 << i; // each new source replaces the recorded cause
      src[i] = 1'b1;
      cyc(1);
      src = '0;
      cyc(1);
      check(sys_rst, 8'h01);
      check(cause, exp);
      wait_rst_done();
      check(clk_sel, DLP_CLK_HSOSC);
      check(gpio, DLP_GPIO_ANALOG);
    end
  endtask

  // both domains powered down with standby asked; exit raises reset
  task automatic t_standby();
    cpd   = 1'b1;
    stby  = 1'b1;
    cidle = 1'b1;
    far.core_pulse(0);
    cyc(6);
    check(sys_mode, DLP_SYS_STANDBY);
    check(core_mode, DLP_DOM_PWRDOWN);
    check(per_mode, DLP_DOM_PWRDOWN);
    check(ctrl_mode, DLP_DOM_PWRDOWN);
    check(ctrl_on, 8'h00);
    check(clk_en, 8'h00);
    cidle = 1'b0;
    far.set_pending(1'b1, 1'b0);
    cyc(2);
    check(sys_rst, 8'h01);
    check(cause, 8'h80);
    wait_rst_done();
    {cpd, stby} = 2'h0;
    far.set_pending(1'b0, 1'b0);
    cyc(2);
    check(sys_mode, DLP_SYS_RUN);
    check(ctrl_on, 8'h01);
    check(clk_en, 8'h01);
  endtask

  // power-on reset mid-run clears the cause that system reset keeps
  task automatic t_por();
    check(cause, 8'h80);
    rst_n = 1'b0;
    cyc(2);
    check(cause, DLP_SRC_POR);
    check(sys_rst, 8'h01);
    rst_n = 1'b1;
    wait_rst_done();
    check(cause, DLP_SRC_POR);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    error_cnt = 0;
    samples_checked = 0;
    t_reset();
    t_cpu();
    t_domain();
    t_sources();
    t_standby();
    t_por();
    tally_and_finish();
  end

  // watchdog: the tests need under two hundred cycles, allow 2000
  initial begin
    #200000;
    error_cnt++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
